/* verilog/pmrc_pkg.sv */
// Constants and types for the power, reset and programming-entry control block.
// Assumes one system clock; the oscillator input is sampled as a synchronous level.
`default_nettype none
package pmrc_pkg;
  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int OSC_PER_MCYC = 12;
  localparam int RST_SAMPLES = 2;
  localparam int ENTRY_BITS = 10;
  localparam int ADDR_BITS = 11;
  localparam int ADDR_HI_BITS = 3;
  localparam int ANALOG_PINS = 5;
  // ----------------------------------------------------------------
  // Power control register fields and reset value
  // ----------------------------------------------------------------
  localparam int PWRCTL_IDLE_BIT = 0;
  localparam int PWRCTL_PDOWN_BIT = 1;
  localparam logic [1:0] PWRCTL_RESET = 2'h0;
  // Entry key: arbitrary value
  localparam logic [9:0] ENTRY_KEY_DEFAULT = 10'h2B5;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMRC_NORMAL = 2'h0,
    PMRC_IDLE = 2'h1,
    PMRC_PDOWN = 2'h3,
    PMRC_PROG = 2'h2
  } pmrc_mode_e;
  typedef struct packed {
    logic osc_prev;
    logic osc_div;
    logic [3:0] osc_cnt;
    logic rst_seen;
    logic int_rst;
    logic entry_open;
    logic [9:0] entry_sh;
    logic [3:0] entry_cnt;
    pmrc_mode_e mode;
    logic [1:0] pwr_ctl;
    logic [10:0] addr;
    logic vp_prev;
    logic mem_write;
    logic irq_wake;
    logic [7:0] p1_out;
    logic [7:0] p1_oe;
  } pmrc_state_s;
endpackage
`default_nettype wire

/* verilog/pmrc_top.sv */
// Power-mode, reset and programming-entry controller for a small microcontroller.
// Assumes all inputs synchronous to clk_sys and the oscillator input much slower.
`timescale 1ns/1ps
`default_nettype none
module pmrc_top
  import pmrc_pkg::*;
#(
  parameter logic [9:0] ENTRY_KEY = ENTRY_KEY_DEFAULT
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Pins
  input wire logic oscillator_input,
  input wire logic reset_pin,
  input wire logic address_byte_select,
  input wire logic verify_program_select,
  input wire logic [7:0] port3_in,
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  // Core side
  input wire logic [7:0] port1_latch,
  input wire logic [7:0] port1_dir,
  input wire logic adc_enable,
  input wire logic pwr_ctl_write,
  input wire logic [1:0] pwr_ctl_wdata,
  input wire logic instr_done,
  input wire logic irq_pending,
  output logic [1:0] power_control_register,
  output logic internal_reset,
  output logic clk_phase,
  output logic core_run,
  output logic adc_pwm_run,
  output logic timers_run,
  output logic osc_run,
  output logic state_retain,
  output logic ram_retain,
  output logic pwm_pin_enable,
  output logic idle_wake,
  output logic prog_mode,
  // Program memory
  output logic [10:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] mem_wdata,
  output logic mem_write
);
  pmrc_state_s q;
  pmrc_state_s d;
  logic osc_edge;
  logic mcyc_tick;

  // ----------------------------------------------------------------
  // Oscillator edge, divider and machine cycle
  // ----------------------------------------------------------------
  // Oscillator halts in power-down, so no edges are counted there
  assign osc_edge = oscillator_input && !q.osc_prev && (q.mode != PMRC_PDOWN);
  assign mcyc_tick = osc_edge && (q.osc_cnt == 4'(OSC_PER_MCYC - 1));

  always_comb
  begin
    d = q;
    d.osc_prev = oscillator_input;
    d.mem_write = 1'b0;
    d.irq_wake = 1'b0;
    if (osc_edge)
    begin
      d.osc_div = !q.osc_div;
      d.osc_cnt = mcyc_tick ? 4'h0 : q.osc_cnt + 4'h1;
    end
    // Reset pin: one sample per machine cycle, two highs in a row
    if (mcyc_tick)
    begin
      d.rst_seen = reset_pin;
      if (reset_pin && q.rst_seen)
        d.int_rst = 1'b1;
      else if (!reset_pin)
        d.int_rst = 1'b0;
    end
    // Reset pin restarts a stopped oscillator, so act on its level
    if (q.mode == PMRC_PDOWN && reset_pin)
      d.int_rst = 1'b1;
    // ----------------------------------------------------------------
    // Power modes
    // ----------------------------------------------------------------
    if (pwr_ctl_write && q.mode == PMRC_NORMAL)
      d.pwr_ctl = pwr_ctl_wdata;
    unique case (q.mode)
      PMRC_NORMAL:
      begin
        // Request waits for its own instruction to finish
        if (instr_done && q.pwr_ctl[PWRCTL_PDOWN_BIT])
          d.mode = PMRC_PDOWN;
        else if (instr_done && q.pwr_ctl[PWRCTL_IDLE_BIT])
          d.mode = PMRC_IDLE;
      end
      PMRC_IDLE:
      begin
        if (irq_pending)
        begin
          d.mode = PMRC_NORMAL;
          d.pwr_ctl[PWRCTL_IDLE_BIT] = 1'b0;
          d.irq_wake = 1'b1;
        end
      end
      PMRC_PDOWN:
      begin
        // Interrupts deliberately ignored here
        d.mode = PMRC_PDOWN;
      end
      PMRC_PROG:
      begin
        if (!address_byte_select)
          d.addr[7:0] = port3_in;
        else
          d.addr[10:8] = port3_in[ADDR_HI_BITS-1:0];
        d.vp_prev = verify_program_select;
        // Program pulse on the falling edge of the select
        if (q.vp_prev && !verify_program_select)
          d.mem_write = 1'b1;
      end
    endcase
    // ----------------------------------------------------------------
    // Programming entry after reset release
    // ----------------------------------------------------------------
    if (q.int_rst && !d.int_rst)
    begin
      d.entry_open = 1'b1;
      d.entry_cnt = 4'h0;
    end
    else if (q.entry_open && osc_edge)
    begin
      // LSB first, strobed by the oscillator input
      d.entry_sh = {reset_pin, q.entry_sh[9:1]};
      d.entry_cnt = q.entry_cnt + 4'h1;
      if (q.entry_cnt == 4'(ENTRY_BITS - 1))
      begin
        d.entry_open = 1'b0;
        if ({reset_pin, q.entry_sh[9:1]} == ENTRY_KEY)
          d.mode = PMRC_PROG;
      end
    end
    // ----------------------------------------------------------------
    // Port 1 drive
    // ----------------------------------------------------------------
    if (q.mode == PMRC_PROG && verify_program_select)
    begin
      d.p1_out = mem_rdata;
      d.p1_oe = 8'hFF;
    end
    else if (q.mode == PMRC_PROG)
    begin
      d.p1_out = 8'h00;
      d.p1_oe = 8'h00;
    end
    else
    begin
      // Latched data keeps driving through idle and power-down
      d.p1_out = port1_latch;
      d.p1_oe = port1_dir;
      if (adc_enable)
        d.p1_oe[ANALOG_PINS-1:0] = '0;
    end
    if (q.int_rst)
    begin
      d.mode = PMRC_NORMAL;
      d.pwr_ctl = PWRCTL_RESET;
      // Keep the entry window that opens as internal reset releases
      d.entry_open = !d.int_rst;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.mode <= PMRC_NORMAL;
      q.pwr_ctl <= PWRCTL_RESET;
      // Oscillator may already be high at release; no false edge then
      q.osc_prev <= 1'b1;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign power_control_register = q.pwr_ctl;
  assign internal_reset = q.int_rst;
  assign clk_phase = q.osc_div;
  assign core_run = (q.mode == PMRC_NORMAL) && !q.int_rst;
  assign adc_pwm_run = (q.mode == PMRC_NORMAL);
  assign timers_run = (q.mode == PMRC_NORMAL) || (q.mode == PMRC_IDLE);
  assign osc_run = (q.mode != PMRC_PDOWN);
  // Core and special registers frozen, not cleared, while idle
  assign state_retain = (q.mode == PMRC_IDLE);
  assign ram_retain = (q.mode == PMRC_IDLE) || (q.mode == PMRC_PDOWN);
  assign pwm_pin_enable = (q.mode == PMRC_NORMAL);
  assign idle_wake = q.irq_wake;
  assign prog_mode = (q.mode == PMRC_PROG);
  assign port1_out = q.p1_out;
  assign port1_oe = q.p1_oe;
  assign mem_addr = q.addr;
  assign mem_wdata = port1_in;
  assign mem_write = q.mem_write;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_two_samples_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mcyc_tick && reset_pin && q.rst_seen) |=> q.int_rst)
    else $error("reset not taken after two high samples");
  reset_one_sample_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(q.int_rst) |-> ($past(q.mode) == PMRC_PDOWN || $past(q.rst_seen)))
    else $error("reset asserted on a single sample");
  divider_toggle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    osc_edge |=> (q.osc_div != $past(q.osc_div)))
    else $error("divider did not toggle");
  idle_after_instr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (q.mode == PMRC_NORMAL && !q.int_rst && !instr_done) |=> (q.mode != PMRC_IDLE))
    else $error("idle entered before instruction end");
  idle_wake_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (q.mode == PMRC_IDLE && irq_pending && !q.int_rst) |=> (q.mode == PMRC_NORMAL && idle_wake))
    else $error("idle not left on interrupt");
  pdown_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (q.mode == PMRC_PDOWN && !reset_pin && !q.int_rst) |=> (q.mode == PMRC_PDOWN))
    else $error("power-down left without reset");
  pdown_osc_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (q.mode == PMRC_PDOWN) |-> (!osc_run && !osc_edge && ram_retain))
    else $error("oscillator running in power-down");
  analog_oe_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (adc_enable && q.mode != PMRC_PROG) |=> (port1_oe[4:0] == 5'h00))
    else $error("analog pin driven while converter on");
  verify_drive_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (q.mode == PMRC_PROG && verify_program_select && !q.int_rst) |=>
      (port1_oe == 8'hFF && port1_out == $past(mem_rdata)))
    else $error("verify data not driven");
  addr_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (q.mode == PMRC_PROG && address_byte_select && !q.int_rst) |=>
      (mem_addr[10:8] == $past(port3_in[2:0]) && mem_addr[7:0] == $past(mem_addr[7:0])))
    else $error("high address byte not captured");
  idle_stops_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (q.mode == PMRC_IDLE) |-> (!core_run && !adc_pwm_run && timers_run && !pwm_pin_enable))
    else $error("wrong units running in idle");
endmodule
`default_nettype wire

/* tb/pmrc_prog_model.sv */
// Board-side model: free-running oscillator input and reset-pin sequences.
// Assumes clk_sys at 50 MHz; the oscillator runs at one sixth of that rate.
`timescale 1ns/1ps
`default_nettype none
module pmrc_prog_model
(
  // Clock
  input wire logic clk_sys,
  // Pins
  output logic oscillator_input,
  output logic reset_pin
);
  // Reset pin has a pull-down, so released means low
  initial
  begin
    oscillator_input = 1'b0;
    reset_pin = 1'b0;
    forever
    begin
      repeat (3) @(posedge clk_sys);
      #1 oscillator_input = ~oscillator_input;
    end
  end
  // Pin changes only on oscillator falls, clear of the sampling rise
  task automatic hold_pin(input int periods);
    @(negedge oscillator_input);
    reset_pin = 1'b1;
    repeat (periods) @(negedge oscillator_input);
    reset_pin = 1'b0;
  endtask
  task automatic send_key(input logic [9:0] key);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge oscillator_input);
      reset_pin = key[i];
    end
    @(negedge oscillator_input);
    reset_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the power, reset and programming-entry controller.
// Assumes the board model makes the oscillator and drives the reset pin.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pmrc_pkg::*;
;
  logic clk_sys, sys_rst, oscillator_input, reset_pin, address_byte_select, cp;
  logic verify_program_select, adc_enable, pwr_ctl_write, instr_done, irq_pending;
  logic [7:0] port3_in, port1_in, port1_out, port1_oe, port1_latch, port1_dir;
  logic [7:0] mem_rdata, mem_wdata;
  logic [1:0] pwr_ctl_wdata, power_control_register;
  logic internal_reset, clk_phase, core_run, adc_pwm_run, timers_run, osc_run;
  logic state_retain, ram_retain, pwm_pin_enable, idle_wake, prog_mode, mem_write;
  logic [10:0] mem_addr;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [23:0] rows [3] = '{24'h000000, 24'hFFFFA5, 24'h3CFA5A};
  pmrc_top i_pmrc_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .oscillator_input(oscillator_input), .reset_pin(reset_pin),
    .address_byte_select(address_byte_select), .verify_program_select(verify_program_select),
    .port3_in(port3_in), .port1_in(port1_in), .port1_out(port1_out), .port1_oe(port1_oe),
    .port1_latch(port1_latch), .port1_dir(port1_dir), .adc_enable(adc_enable),
    .pwr_ctl_write(pwr_ctl_write), .pwr_ctl_wdata(pwr_ctl_wdata), .instr_done(instr_done),
    .irq_pending(irq_pending), .power_control_register(power_control_register),
    .internal_reset(internal_reset), .clk_phase(clk_phase), .core_run(core_run),
    .adc_pwm_run(adc_pwm_run), .timers_run(timers_run), .osc_run(osc_run),
    .state_retain(state_retain), .ram_retain(ram_retain), .pwm_pin_enable(pwm_pin_enable),
    .idle_wake(idle_wake), .prog_mode(prog_mode), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_write(mem_write));
  pmrc_prog_model i_pmrc_prog_model (.clk_sys(clk_sys),
    .oscillator_input(oscillator_input), .reset_pin(reset_pin));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [10:0] seen, input logic [10:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_rst_low();
    for (int n = 0; n < 200 && internal_reset !== 1'b0; n++)
      tick();
    check(internal_reset, 1'b0, "internal_reset");
  endtask
  // Long hold so two machine-cycle samples land whatever the phase
  task automatic enter(input logic [9:0] key);
    i_pmrc_prog_model.hold_pin(36);
    check(internal_reset, 1'b1, "internal_reset");
    wait_rst_low();
    i_pmrc_prog_model.send_key(key);
    tick();
  endtask
  task automatic pwr_ctl_wr(input logic [1:0] v);
    pwr_ctl_write = 1'b1;
    pwr_ctl_wdata = v;
    tick();
    pwr_ctl_write = 1'b0;
    instr_done = 1'b1;
    tick();
    instr_done = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  initial
  begin
    {sys_rst, address_byte_select, verify_program_select, adc_enable} = 4'h8;
    {pwr_ctl_write, instr_done, irq_pending, pwr_ctl_wdata} = 5'h00;
    {port3_in, port1_in, port1_latch, port1_dir, mem_rdata} = 40'h0;
    repeat (16) tick();
    check(power_control_register, PWRCTL_RESET, "pwr_ctl");
    check(port1_oe, 8'h00, "port1_oe");
    check({mem_write, clk_phase, internal_reset}, 3'h0, "reset_outs");
    sys_rst = 1'b0;
    cp = clk_phase;
    repeat (6) tick();
    check(clk_phase, !cp, "clk_phase");
    {adc_enable, port1_dir, port1_latch} = 17'h1FFC3;
    repeat (2) tick();
    check(port1_oe, 8'hE0, "port1_oe");
    // Converter stays off through idle and wake: references need settling
    adc_enable = 1'b0;
    pwr_ctl_wr(2'h1);
    check({core_run, adc_pwm_run, timers_run}, 3'h1, "idle_run");
    check({osc_run, state_retain, ram_retain}, 3'h7, "idle_keep");
    check({port1_oe, port1_out}, 16'hFFC3, "idle_port");
    pwr_ctl_wr(2'h2);
    check(power_control_register, 2'h1, "pwr_ctl_refused");
    irq_pending = 1'b1;
    tick();
    irq_pending = 1'b0;
    check({idle_wake, core_run, power_control_register}, 4'hC, "wake");
    pwr_ctl_wr(2'h3);
    check({osc_run, core_run, ram_retain}, 3'h1, "pdown");
    irq_pending = 1'b1;
    repeat (3) tick();
    irq_pending = 1'b0;
    check({idle_wake, core_run}, 2'h0, "pdown_irq");
    check(port1_out, 8'hC3, "pdown_port");
    enter(~ENTRY_KEY_DEFAULT);
    check({prog_mode, osc_run}, 2'h1, "bad_key");
    i_pmrc_prog_model.hold_pin(12);
    tick();
    check(internal_reset, 1'b0, "one_mcyc");
    enter(ENTRY_KEY_DEFAULT);
    check(prog_mode, 1'b1, "prog_mode");
    foreach (rows[i])
    begin
      {address_byte_select, port3_in} = {1'b0, rows[i][23:16]};
      tick();
      {address_byte_select, port3_in} = {1'b1, rows[i][15:8]};
      tick();
      {verify_program_select, mem_rdata} = {1'b1, rows[i][7:0]};
      repeat (2) tick();
      check(mem_addr, {rows[i][10:8], rows[i][23:16]}, "mem_addr");
      check({port1_oe, port1_out}, {8'hFF, rows[i][7:0]}, "verify");
      {verify_program_select, port1_in} = {1'b0, ~rows[i][7:0]};
      tick();
      check({mem_write, mem_wdata}, {1'b1, ~rows[i][7:0]}, "program");
      check(port1_oe, 8'h00, "program_oe");
      tick();
      check(mem_write, 1'b0, "write_pulse");
    end
    print_verdict();
  end
endmodule
`default_nettype wire
